/* inc/jid_defines.svh */
// Constants of the boundary-scan instruction decoder
`ifndef JID_DEFINES_SVH
`define JID_DEFINES_SVH

`define JID_IR_W 4
`define JID_IR_EXTEST 4'h0
`define JID_IR_SAMPLE 4'h1
`define JID_IR_IDCODE 4'h2
`define JID_IR_HIGHZ 4'h3
`define JID_IR_BYPASS 4'hf
`define JID_IR_CAPTURE 4'h1
`define JID_IR_RESET `JID_IR_IDCODE
`define JID_ID_W 32
`define JID_ID_LSB 1'b1
`define JID_BYP_CAPTURE 1'b0
`define JID_TGL_RESET 1'b0
`define JID_TLR_RESET 1'b1

`endif

/* inc/jid_pkg.sv */
// Types of the boundary-scan instruction decoder
`default_nettype none

package jid_pkg;

   typedef enum logic [15:0] {
      JID_TLR = 16'h0001,
      JID_RTI = 16'h0002,
      JID_SEL_DR = 16'h0004,
      JID_CAP_DR = 16'h0008,
      JID_SH_DR = 16'h0010,
      JID_EX1_DR = 16'h0020,
      JID_PA_DR = 16'h0040,
      JID_EX2_DR = 16'h0080,
      JID_UPD_DR = 16'h0100,
      JID_SEL_IR = 16'h0200,
      JID_CAP_IR = 16'h0400,
      JID_SH_IR = 16'h0800,
      JID_EX1_IR = 16'h1000,
      JID_PA_IR = 16'h2000,
      JID_EX2_IR = 16'h4000,
      JID_UPD_IR = 16'h8000
   } jid_tap_state_t;

   typedef struct packed {
      logic extest;
      logic highz;
   } jid_mode_t;

   typedef struct packed {
      logic sel_bsr;
      logic sel_id;
      logic sel_byp;
   } jid_path_t;

endpackage : jid_pkg

`default_nettype wire

/* hw/jid_top.sv */
// Test access port with instruction decoding and boundary scan
//
// Behaviour
// - Four-bit instruction register, sixteen possible codes
// - Instruction shifts in only during Shift-IR
// - Current instruction selects the data-scan path
// - Unselected data registers stay untouched
// - Code 0x00: external test through boundary register
// - Code 0x01: sample pins, device stays functional
// - Sample instruction also preloads boundary update values
// - Code 0x02: 32-bit identification register selected
// - Identification scan leaves device operation alone
// - Identification selected after reset or Test-Logic-Reset
// - Code 0x03: all outputs off, bypass selected
// - Bypass shifting keeps outputs disabled
// - Code 0x0F: bypass, device stays functional
// - Bypass stage captures zero in Capture-DR
// - Instruction latched on falling edge in Update-IR
// - Tester resets the port; five TMS highs reset
// - Identification holds version, part, maker, one
`include "jid_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module jid_top import jid_pkg::*; #(
   parameter int N_IN = 4,
   parameter int N_OUT = 4,
   // Arbitrary value
   parameter logic [3:0] ID_VERSION = 4'h0,
   // Arbitrary value
   parameter logic [15:0] ID_PART = 16'h1234,
   // Arbitrary value
   parameter logic [10:0] ID_MAKER = 11'h0a5
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic tck,
   input wire logic trst_n,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe,
   input wire logic [N_OUT-1:0] core_out,
   input wire logic [N_OUT-1:0] core_oe,
   output logic [N_IN-1:0] core_in,
   input wire logic [N_IN-1:0] pin_in,
   output logic [N_OUT-1:0] pin_out,
   output logic [N_OUT-1:0] pin_oe,
   output jid_mode_t test_mode
);

   localparam int BSR_W = N_IN + 2 * N_OUT;

   if (N_IN < 1 || N_OUT < 1) begin : g_bad_size
      $error("jid_top needs at least one input and one output cell");
   end

   ////////////////////////////////////////////////////////////////////
   // Declarations

   jid_tap_state_t state_reg;
   jid_tap_state_t state_next;
   logic [`JID_IR_W-1:0] ir_shift_reg;
   logic [`JID_IR_W-1:0] ir_reg;
   logic byp_reg;
   logic [`JID_ID_W-1:0] id_reg;
   logic [BSR_W-1:0] bsr_reg;
   logic [BSR_W-1:0] upd_reg;
   logic tdo_reg;
   logic tdo_oe_reg;
   logic tgl_reg;
   logic tlr_reg;
   logic [N_IN-1:0] tin_s1_reg;
   logic [N_IN-1:0] tin_s2_reg;
   logic [2*N_OUT-1:0] tout_s1_reg;
   logic [2*N_OUT-1:0] tout_s2_reg;

   logic tgl_s1_reg;
   logic tgl_s2_reg;
   logic tgl_s3_reg;
   logic tlr_s1_reg;
   logic tlr_s2_reg;
   logic [N_IN-1:0] pin_s1_reg;
   logic [N_IN-1:0] pin_s2_reg;
   jid_mode_t mode_reg;
   logic [BSR_W-1:0] upd_cap_reg;
   logic [N_IN-1:0] core_in_reg;
   logic [N_OUT-1:0] pin_out_reg;
   logic [N_OUT-1:0] pin_oe_reg;

   ////////////////////////////////////////////////////////////////////
   // Instruction decode

   wire is_extest = (ir_reg == `JID_IR_EXTEST);
   wire is_sample = (ir_reg == `JID_IR_SAMPLE);
   wire is_idcode = (ir_reg == `JID_IR_IDCODE);
   wire is_highz = (ir_reg == `JID_IR_HIGHZ);
   wire is_bypass = ~(is_extest | is_sample | is_idcode | is_highz);

   jid_path_t path;
   jid_mode_t mode_tck;
   assign path.sel_bsr = is_extest | is_sample;
   assign path.sel_id = is_idcode;
   assign path.sel_byp = is_highz | is_bypass;
   assign mode_tck.extest = is_extest;
   assign mode_tck.highz = is_highz;

   wire st_tlr = (state_reg == JID_TLR);
   wire st_cap_dr = (state_reg == JID_CAP_DR);
   wire st_sh_dr = (state_reg == JID_SH_DR);
   wire st_upd_dr = (state_reg == JID_UPD_DR);
   wire st_cap_ir = (state_reg == JID_CAP_IR);
   wire st_sh_ir = (state_reg == JID_SH_IR);
   wire st_upd_ir = (state_reg == JID_UPD_IR);
   wire st_leave_tlr = st_tlr && (state_next != JID_TLR);

   wire [`JID_ID_W-1:0] id_value = {ID_VERSION, ID_PART, ID_MAKER,
      `JID_ID_LSB};
   wire [BSR_W-1:0] bsr_sample = {tout_s2_reg, tin_s2_reg};
   wire dr_tdo = path.sel_bsr ? bsr_reg[0] :
      (path.sel_id ? id_reg[0] : byp_reg);
   wire tdo_next = st_sh_ir ? ir_shift_reg[0] : dr_tdo;

   ////////////////////////////////////////////////////////////////////
   // Port controller state sequence

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         JID_TLR: state_next = tms ? JID_TLR : JID_RTI;
         JID_RTI: state_next = tms ? JID_SEL_DR : JID_RTI;
         JID_SEL_DR: state_next = tms ? JID_SEL_IR : JID_CAP_DR;
         JID_CAP_DR: state_next = tms ? JID_EX1_DR : JID_SH_DR;
         JID_SH_DR: state_next = tms ? JID_EX1_DR : JID_SH_DR;
         JID_EX1_DR: state_next = tms ? JID_UPD_DR : JID_PA_DR;
         JID_PA_DR: state_next = tms ? JID_EX2_DR : JID_PA_DR;
         JID_EX2_DR: state_next = tms ? JID_UPD_DR : JID_SH_DR;
         JID_UPD_DR: state_next = tms ? JID_SEL_DR : JID_RTI;
         JID_SEL_IR: state_next = tms ? JID_TLR : JID_CAP_IR;
         JID_CAP_IR: state_next = tms ? JID_EX1_IR : JID_SH_IR;
         JID_SH_IR: state_next = tms ? JID_EX1_IR : JID_SH_IR;
         JID_EX1_IR: state_next = tms ? JID_UPD_IR : JID_PA_IR;
         JID_PA_IR: state_next = tms ? JID_EX2_IR : JID_PA_IR;
         JID_EX2_IR: state_next = tms ? JID_UPD_IR : JID_SH_IR;
         JID_UPD_IR: state_next = tms ? JID_SEL_DR : JID_RTI;
         default: state_next = JID_TLR;
      endcase
   end

   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         state_reg <= JID_TLR;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Instruction shift stage

   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         ir_shift_reg <= `JID_IR_CAPTURE;
      end else if (st_cap_ir) begin
         ir_shift_reg <= `JID_IR_CAPTURE;
      end else if (st_sh_ir) begin
         ir_shift_reg <= {tdi, ir_shift_reg[`JID_IR_W-1:1]};
      end
   end

   // Current instruction, loaded on the falling edge
   always_ff @(negedge tck or negedge trst_n) begin
      if (!trst_n) begin
         ir_reg <= `JID_IR_RESET;
      end else if (st_tlr) begin
         ir_reg <= `JID_IR_RESET;
      end else if (st_upd_ir) begin
         ir_reg <= ir_shift_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Data registers

   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         byp_reg <= `JID_BYP_CAPTURE;
      end else if (path.sel_byp && st_cap_dr) begin
         byp_reg <= `JID_BYP_CAPTURE;
      end else if (path.sel_byp && st_sh_dr) begin
         byp_reg <= tdi;
      end
   end

   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         id_reg <= '0;
      end else if (path.sel_id && st_cap_dr) begin
         id_reg <= id_value;
      end else if (path.sel_id && st_sh_dr) begin
         id_reg <= {tdi, id_reg[`JID_ID_W-1:1]};
      end
   end

   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         bsr_reg <= '0;
      end else if (path.sel_bsr && st_cap_dr) begin
         bsr_reg <= bsr_sample;
      end else if (path.sel_bsr && st_sh_dr) begin
         bsr_reg <= {tdi, bsr_reg[BSR_W-1:1]};
      end
   end

   // Update stage of the boundary cells, serial output
   always_ff @(negedge tck or negedge trst_n) begin
      if (!trst_n) begin
         upd_reg <= '0;
         tdo_reg <= 1'b0;
         tdo_oe_reg <= 1'b0;
      end else begin
         if (path.sel_bsr && st_upd_dr) begin
            upd_reg <= bsr_reg;
         end
         tdo_reg <= tdo_next;
         tdo_oe_reg <= st_sh_ir | st_sh_dr;
      end
   end

   // Pin levels seen by the capture stage
   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         tin_s1_reg <= '0;
         tin_s2_reg <= '0;
         tout_s1_reg <= '0;
         tout_s2_reg <= '0;
      end else begin
         tin_s1_reg <= pin_in;
         tin_s2_reg <= tin_s1_reg;
         tout_s1_reg <= {pin_oe_reg, pin_out_reg};
         tout_s2_reg <= tout_s1_reg;
      end
   end

   // Announces a new instruction or update value to the clk side
   // Leaving Test-Logic-Reset announces too: a short pass through it
   // may fall between two clk edges and miss the level synchroniser
   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         tgl_reg <= `JID_TGL_RESET;
      end else if (st_upd_ir || st_upd_dr || st_leave_tlr) begin
         tgl_reg <= ~tgl_reg;
      end
   end

   // Test-Logic-Reset level from a flop for the clk side
   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         tlr_reg <= `JID_TLR_RESET;
      end else begin
         tlr_reg <= (state_next == JID_TLR);
      end
   end

   assign tdo = tdo_reg;
   assign tdo_oe = tdo_oe_reg;

   ////////////////////////////////////////////////////////////////////
   // System clock side

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tgl_s1_reg <= `JID_TGL_RESET;
         tgl_s2_reg <= `JID_TGL_RESET;
         tgl_s3_reg <= `JID_TGL_RESET;
         tlr_s1_reg <= 1'b1;
         tlr_s2_reg <= 1'b1;
         pin_s1_reg <= '0;
         pin_s2_reg <= '0;
      end else begin
         tgl_s1_reg <= tgl_reg;
         tgl_s2_reg <= tgl_s1_reg;
         tgl_s3_reg <= tgl_s2_reg;
         tlr_s1_reg <= tlr_reg;
         tlr_s2_reg <= tlr_s1_reg;
         pin_s1_reg <= pin_in;
         pin_s2_reg <= pin_s1_reg;
      end
   end

   wire tgl_evt = tgl_s2_reg ^ tgl_s3_reg;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mode_reg <= '0;
         upd_cap_reg <= '0;
      end else if (tlr_s2_reg) begin
         mode_reg <= '0;
      end else if (tgl_evt) begin
         mode_reg <= mode_tck;
         upd_cap_reg <= upd_reg;
      end
   end

   wire [N_IN-1:0] upd_in = upd_cap_reg[N_IN-1:0];
   wire [N_OUT-1:0] upd_out = upd_cap_reg[N_IN+N_OUT-1:N_IN];
   wire [N_OUT-1:0] upd_oe = upd_cap_reg[BSR_W-1:N_IN+N_OUT];

   // Pad multiplexers, one per cell
   for (genvar i = 0; i < N_OUT; i++) begin : g_out
      wire out_sel = mode_reg.extest ? upd_out[i] : core_out[i];
      wire oe_sel = mode_reg.highz ? 1'b0 :
         (mode_reg.extest ? upd_oe[i] : core_oe[i]);
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            pin_out_reg[i] <= 1'b0;
            pin_oe_reg[i] <= 1'b0;
         end else begin
            pin_out_reg[i] <= out_sel;
            pin_oe_reg[i] <= oe_sel;
         end
      end
   end

   for (genvar j = 0; j < N_IN; j++) begin : g_in
      wire in_sel = mode_reg.extest ? upd_in[j] : pin_s2_reg[j];
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            core_in_reg[j] <= 1'b0;
         end else begin
            core_in_reg[j] <= in_sel;
         end
      end
   end

   assign pin_out = pin_out_reg;
   assign pin_oe = pin_oe_reg;
   assign core_in = core_in_reg;
   assign test_mode = mode_reg;

endmodule : jid_top

`default_nettype wire

/* tb/jid_props.sv */
// Assertions on the test port and pin control
`timescale 1ns/1ps
`default_nettype none
module jid_props import jid_pkg::*; #(
   parameter int N_IN = 4,
   parameter int N_OUT = 4
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic tck,
   input wire logic trst_n,
   input wire logic tms,
   input wire logic tdo,
   input wire logic tdo_oe,
   input wire logic [N_OUT-1:0] core_out,
   input wire logic [N_OUT-1:0] core_oe,
   input wire logic [N_IN-1:0] core_in,
   input wire logic [N_IN-1:0] pin_in,
   input wire logic [N_OUT-1:0] pin_out,
   input wire logic [N_OUT-1:0] pin_oe,
   input wire jid_mode_t test_mode
);
   a_highz_off: assert property (@(posedge clk)
      disable iff (!rstn) test_mode.highz |=> pin_oe == '0)
      else $error("pin enabled in high-z");
   a_func_follow: assert property (@(posedge clk)
      disable iff (!rstn) $past(rstn) && test_mode == 2'b00 &&
      $past(test_mode) == 2'b00 |-> pin_out == $past(core_out) &&
      pin_oe == $past(core_oe)) else $error("pins not following core");
   a_core_sync: assert property (@(posedge clk) disable iff (!rstn)
      $past(rstn, 3) && $past(test_mode) == 2'b00 |->
      core_in == $past(pin_in, 3))
      else $error("core input not synced");
   a_mode_excl: assert property (@(posedge clk) disable iff (!rstn)
      test_mode.extest |-> !test_mode.highz) else $error("two modes");
   a_mode_reset: assert property (@(posedge clk) disable iff (!rstn)
      (!trst_n) [*4] |-> test_mode == 2'b00) else $error("mode kept");
   a_trst_quiet: assert property (@(posedge clk) disable iff (!rstn)
      !trst_n |-> !tdo_oe && !tdo) else $error("tdo driven in reset");
   a_tap_five: assert property (@(posedge tck) disable iff (!trst_n)
      tms [*5] |=> !tdo_oe) else $error("tms reset failed");
   a_oe_enter: assert property (@(posedge tck) disable iff (!trst_n)
      $rose(tdo_oe) |-> !$past(tms)) else $error("tdo on outside shift");
   a_oe_leave: assert property (@(posedge tck) disable iff (!trst_n)
      $fell(tdo_oe) |-> $past(tms)) else $error("tdo off inside shift");
endmodule : jid_props
bind jid_top jid_props #(.N_IN(N_IN), .N_OUT(N_OUT)) u_props (.clk(clk),
   .rstn(rstn), .tck(tck), .trst_n(trst_n), .tms(tms), .tdo(tdo),
   .tdo_oe(tdo_oe), .core_out(core_out), .core_oe(core_oe),
   .core_in(core_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
   .test_mode(test_mode));
`default_nettype wire

/* tb/jid_tester.sv */
// Boundary-scan test controller model driving the test port
`timescale 1ns/1ps
`default_nettype none
module jid_tester (
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // One link cycle; tck idles low between frames
   task automatic step(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #7.5 q = tdo;
      tck = 1'b1;
      #7.5 tck = 1'b0;
   endtask : step
   // Five highs on tms, then idle
   task automatic tap_reset();
      logic q;
      repeat (5) step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
   endtask : tap_reset
   // Scan n bits LSB first, from idle back to idle
   task automatic scan(input logic ir, input int n, input logic [31:0] din,
      output logic [31:0] dout);
      logic q;
      dout = '0;
      step(1'b1, 1'b0, q);
      if (ir) step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
      step(1'b0, 1'b0, q);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
   endtask : scan
endmodule : jid_tester
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench of the test port decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [31:0] ID_EXP = {4'h0, 16'h1234, 11'h0a5, 1'b1};
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic trst_n = 1'b0;
   logic [3:0] core_out = 4'h5;
   logic [3:0] core_oe = 4'hc;
   logic [3:0] pin_in = 4'ha;
   wire logic tck, tms, tdi, tdo, tdo_oe;
   logic [3:0] core_in, pin_out, pin_oe;
   jid_pkg::jid_mode_t test_mode;
   int n_mismatch = 0;
   int cmp_count = 0;
   logic [31:0] rd;
   always #25 clk = ~clk;
   jid_top dut (.clk(clk), .rstn(rstn), .tck(tck), .trst_n(trst_n),
      .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .core_out(core_out),
      .core_oe(core_oe), .core_in(core_in), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .test_mode(test_mode));
   jid_tester tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic settle();
      repeat (6) @(negedge clk);
   endtask : settle
   task automatic load(input logic [3:0] c);
      settle();
      tester.scan(1'b1, 4, {28'h0, c}, rd);
      chk(rd[3:0], 4'h1);
      settle();
   endtask : load
   ////////////////////////////////////////////////////////////////////////
   task automatic t_idcode();
      tester.scan(1'b0, 32, 32'h0, rd);
      chk(rd, ID_EXP);
      chk(test_mode, 2'b00);
   endtask : t_idcode
   task automatic t_bypass();
      for (int c = 4; c < 16; c++) begin
         load(c[3:0]);
         tester.scan(1'b0, 2, 32'h3, rd);
         chk(rd[1:0], 2'b10);
         chk({test_mode, pin_out, pin_oe}, {2'b00, core_out, core_oe});
      end
   endtask : t_bypass
   task automatic t_highz();
      load(4'h3);
      chk({test_mode, pin_oe}, {2'b01, 4'h0});
      tester.scan(1'b0, 2, 32'h1, rd);
      chk(rd[1:0], 2'b10);
      @(negedge clk);
      core_oe = 4'hf;
      settle();
      chk(pin_oe, 4'h0);
   endtask : t_highz
   task automatic t_sample();
      load(4'h1);
      chk({test_mode, core_in}, {2'b00, pin_in});
      tester.scan(1'b0, 12, 32'hf95, rd);
      chk(rd[11:0], {core_oe, core_out, pin_in});
      settle();
      chk({pin_out, pin_oe}, {core_out, core_oe});
   endtask : t_sample
   task automatic t_extest();
      load(4'h0);
      chk({test_mode, pin_out, pin_oe, core_in},
         {2'b10, 4'h9, 4'hf, 4'h5});
      @(negedge clk);
      pin_in = 4'h6;
      settle();
      tester.scan(1'b0, 12, 32'h360, rd);
      chk(rd[11:0], {4'hf, 4'h9, pin_in});
      settle();
      chk({pin_out, pin_oe, core_in}, 12'h630);
   endtask : t_extest
   task automatic t_reset();
      logic q;
      tester.tap_reset();
      settle();
      chk({test_mode, pin_out, pin_oe}, {2'b00, core_out, core_oe});
      t_idcode();
      load(4'h3);
      chk(test_mode, 2'b01);
      trst_n = 1'b0;
      settle();
      chk({test_mode, pin_oe, tdo_oe}, {2'b00, core_oe, 1'b0});
      trst_n = 1'b1;
      tester.step(1'b0, 1'b0, q);
      t_idcode();
   endtask : t_reset
   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (10) @(negedge clk);
      rstn = 1'b1;
      repeat (6) @(negedge clk);
      trst_n = 1'b1;
      #20;
      tester.tap_reset();
      t_idcode();
      t_bypass();
      t_highz();
      t_sample();
      t_extest();
      t_reset();
      report_and_stop();
   end
   initial begin
      #100000;
      n_mismatch++;
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
